//--- rtl/timer2_ctl_pkg.sv
/*
 * constants for the flag, asynchronous-status and general timer control logic of timer 2:
 * register offsets, bit positions and reset values.
 * assumes a byte-wide register port with separate data-space and dedicated-i/o address decode.
 */
// Functional notes
// - overflow irq needs enable, global enable, flag
// - compare b match sets compare b flag
// - compare a match sets compare a flag
// - counter overflow sets overflow flag, except in phase-correct pwm
// - vector execution clears its own flag
// - writing one clears flag, zero keeps
// - compare irq needs global, channel enable, flag
// - phase-correct pwm: overflow flag at bottom turn
// - ext clock enable with async select opens buffer, stops crystal
// - async select picks oscillator, else io clock
// - async write sets busy until transfer done
// - sync mode holds both prescaler reset bits
// - sync mode cleared clears shared reset bit, async one once done
// - async prescaler reset clears when done
// - shared prescaler reset clears unless sync mode
// - data-space and i/o offsets both decode for flags and general control; 0xb0-0xb6 data-space only
`default_nettype none
package timer2_ctl_pkg;
   // ----------------------------------------------------------------------
   // address map
   // ----------------------------------------------------------------------
   localparam logic [7:0] IO_SPACE_BIAS   = 8'h20;
   localparam logic [7:0] IRQ_FLAGS_OFS   = 8'h37;
   localparam logic [7:0] GEN_CTRL_OFS    = 8'h43;
   localparam logic [7:0] ASYNC_STAT_OFS  = 8'hb6;
   localparam logic [7:0] CONTROL_A_OFS   = 8'hb0;
   localparam logic [7:0] CONTROL_B_OFS   = 8'hb1;
   localparam logic [7:0] COUNTER_OFS     = 8'hb2;
   localparam logic [7:0] COMPARE_A_OFS   = 8'hb3;
   localparam logic [7:0] COMPARE_B_OFS   = 8'hb4;
   // ----------------------------------------------------------------------
   // bit positions
   // ----------------------------------------------------------------------
   localparam int OVF_BIT        = 0;
   localparam int CMP_A_BIT      = 1;
   localparam int CMP_B_BIT      = 2;
   localparam int EXT_CLK_BIT    = 6;
   localparam int ASYNC_SEL_BIT  = 5;
   localparam int SYNC_MODE_BIT  = 7;
   localparam int ASYNC_PSR_BIT  = 1;
   localparam int SHARED_PSR_BIT = 0;
   localparam int BUSY_COUNTER   = 4;
   localparam int BUSY_CMP_A     = 3;
   localparam int BUSY_CMP_B     = 2;
   localparam int BUSY_CTRL_A    = 1;
   localparam int BUSY_CTRL_B    = 0;
   localparam int NUM_FLAGS      = 3;
   localparam int NUM_BUSY       = 5;
   // ----------------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------------
   localparam logic [7:0] REG_RESET   = 8'h00;
   localparam logic [2:0] FLAGS_RESET = 3'h0;
   localparam logic [4:0] BUSY_RESET  = 5'h00;
endpackage
`default_nettype wire

//--- rtl/sticky_bits.sv
/*
 * row of sticky bits: hardware set, clear by strobe, set wins over clear.
 * assumes set and clear are synchronous to core_clk.
 */
`timescale 1ns/1ns
`default_nettype none
module sticky_bits #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         core_clk,
   input  wire logic         rst_b,
   input  wire logic         ce,
   // control
   input  wire logic [W-1:0] set_bits,
   input  wire logic [W-1:0] clr_bits,
   // state
   output logic      [W-1:0] q
);
   // a set arriving with a clear must not be lost
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else if (ce) begin
         q <= set_bits | (q & ~clr_bits);
      end
   end
endmodule
`default_nettype wire

//--- rtl/timer2_async_flag_prescaler_ctl.sv
/*
 * interrupt flags, asynchronous clock status and general timer control for timer 2.
 * assumes the counter core reports overflow, bottom turn, compare matches and update
 * transfers as one-cycle pulses on core_clk, and the cpu gives vector acknowledges.
 */
`timescale 1ns/1ns
`default_nettype none
module timer2_async_flag_prescaler_ctl
   import timer2_ctl_pkg::*;
(
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst_b,
   input  wire logic       ce,
   // register port
   input  wire logic [7:0] addr,
   input  wire logic       io_space,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   input  wire logic [7:0] wdata,
   output logic      [7:0] rdata,
   // cpu side
   input  wire logic       global_irq_enable,
   input  wire logic       overflow_irq_enable,
   input  wire logic       cmp_a_irq_enable,
   input  wire logic       cmp_b_irq_enable,
   input  wire logic [2:0] vector_ack,
   output logic            overflow_irq,
   output logic            cmp_a_irq,
   output logic            cmp_b_irq,
   // counter core
   input  wire logic       counter_overflow,
   input  wire logic       phase_correct_mode,
   input  wire logic       bottom_turn,
   input  wire logic       cmp_a_match,
   input  wire logic       cmp_b_match,
   input  wire logic [4:0] update_done,
   input  wire logic       async_psr_done,
   // clock and prescaler control
   output logic            async_clock_select,
   output logic            ext_clock_buffer_en,
   output logic            crystal_osc_run,
   output logic            async_prescaler_reset,
   output logic            shared_prescaler_reset
);
   // ----------------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------------
   logic       hit_flags;
   logic       hit_gen;
   logic       hit_async;
   logic [4:0] hit_busy;
   logic       wr_flags;
   logic       wr_gen;
   logic       wr_async;

   // the status register at 0xb6 has no dedicated i/o address
   always_comb begin
      hit_flags   = io_space ? (addr == IRQ_FLAGS_OFS - IO_SPACE_BIAS) : (addr == IRQ_FLAGS_OFS);
      hit_gen     = io_space ? (addr == GEN_CTRL_OFS - IO_SPACE_BIAS) : (addr == GEN_CTRL_OFS);
      hit_async   = !io_space && (addr == ASYNC_STAT_OFS);
      hit_busy    = '0;
      if (!io_space) begin
         hit_busy[BUSY_COUNTER] = (addr == COUNTER_OFS);
         hit_busy[BUSY_CMP_A]   = (addr == COMPARE_A_OFS);
         hit_busy[BUSY_CMP_B]   = (addr == COMPARE_B_OFS);
         hit_busy[BUSY_CTRL_A]  = (addr == CONTROL_A_OFS);
         hit_busy[BUSY_CTRL_B]  = (addr == CONTROL_B_OFS);
      end
      wr_flags = wr_en && hit_flags;
      wr_gen   = wr_en && hit_gen;
      wr_async = wr_en && hit_async;
   end

   // ----------------------------------------------------------------------
   // interrupt flags
   // ----------------------------------------------------------------------
   logic [2:0] flag_set;
   logic [2:0] flag_clr;
   logic [2:0] flags;

   always_comb begin
      flag_set            = '0;
      // in phase-correct pwm the overflow flag marks the turn at bottom
      flag_set[OVF_BIT]   = phase_correct_mode ? bottom_turn : counter_overflow;
      flag_set[CMP_A_BIT] = cmp_a_match;
      flag_set[CMP_B_BIT] = cmp_b_match;
      flag_clr            = vector_ack | (wr_flags ? wdata[2:0] : 3'h0);
   end

   sticky_bits #(.W(NUM_FLAGS)) u_flags (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .ce       (ce),
      .set_bits (flag_set),
      .clr_bits (flag_clr),
      .q        (flags)
   );

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         overflow_irq <= 1'b0;
         cmp_a_irq    <= 1'b0;
         cmp_b_irq    <= 1'b0;
      end else if (ce) begin
         overflow_irq <= global_irq_enable && overflow_irq_enable && flags[OVF_BIT];
         cmp_a_irq    <= global_irq_enable && cmp_a_irq_enable && flags[CMP_A_BIT];
         cmp_b_irq    <= global_irq_enable && cmp_b_irq_enable && flags[CMP_B_BIT];
      end
   end

   // ----------------------------------------------------------------------
   // asynchronous clock status
   // ----------------------------------------------------------------------
   logic       ext_clock_input_enable;
   logic [4:0] busy_set;
   logic [4:0] busy_clr;
   logic [4:0] update_busy;

   // software is trusted to set the external clock bit first and to rewrite
   // the timer registers after a select change; nothing here guards that
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ext_clock_input_enable <= 1'b0;
         async_clock_select     <= 1'b0;
      end else if (ce && wr_async) begin
         ext_clock_input_enable <= wdata[EXT_CLK_BIT];
         async_clock_select     <= wdata[ASYNC_SEL_BIT];
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ext_clock_buffer_en <= 1'b0;
         crystal_osc_run     <= 1'b0;
      end else if (ce) begin
         ext_clock_buffer_en <= ext_clock_input_enable && async_clock_select;
         crystal_osc_run     <= !ext_clock_input_enable && async_clock_select;
      end
   end

   always_comb begin
      busy_set = (wr_en && async_clock_select) ? hit_busy : 5'h00;
      // synchronous clocking writes straight through, so busy is held low
      busy_clr = update_done | {NUM_BUSY{!async_clock_select}};
   end

   sticky_bits #(.W(NUM_BUSY)) u_busy (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .ce       (ce),
      .set_bits (busy_set),
      .clr_bits (busy_clr),
      .q        (update_busy)
   );

   // ----------------------------------------------------------------------
   // general timer control
   // ----------------------------------------------------------------------
   logic sync_mode_hold;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sync_mode_hold <= 1'b0;
      end else if (ce && wr_gen) begin
         sync_mode_hold <= wdata[SYNC_MODE_BIT];
      end
   end

   // a written reset bit stands for at least one cycle before hardware clears it
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         shared_prescaler_reset <= 1'b0;
      end else if (ce) begin
         if (wr_gen) begin
            shared_prescaler_reset <= wdata[SHARED_PSR_BIT];
         end else if (!sync_mode_hold) begin
            shared_prescaler_reset <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         async_prescaler_reset <= 1'b0;
      end else if (ce) begin
         if (wr_gen) begin
            async_prescaler_reset <= wdata[ASYNC_PSR_BIT];
         end else if (!sync_mode_hold) begin
            // asynchronous prescaler needs the slow clock to finish its reset
            if (!async_clock_select || async_psr_done) begin
               async_prescaler_reset <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata <= REG_RESET;
      end else if (ce && rd_en) begin
         if (hit_flags) begin
            rdata <= {5'h00, flags};
         end else if (hit_gen) begin
            rdata <= {sync_mode_hold, 5'h00, async_prescaler_reset, shared_prescaler_reset};
         end else if (hit_async) begin
            rdata <= {1'b0, ext_clock_input_enable, async_clock_select, update_busy};
         end else begin
            rdata <= 8'h00;
         end
      end
   end

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   sequence s_release_sync;
      ce && wr_gen && !wdata[SYNC_MODE_BIT];
   endsequence

   sequence s_quiet_cycle;
      ce && !wr_gen;
   endsequence

   a_ovf_irq_gate: assert property (ce |=> overflow_irq == $past(global_irq_enable && overflow_irq_enable
                                                                 && flags[OVF_BIT]))
      else $error("overflow irq does not follow its gate");
   a_cmp_irq_gate: assert property (ce |=> (cmp_a_irq == $past(global_irq_enable && cmp_a_irq_enable
                                     && flags[CMP_A_BIT])) && (cmp_b_irq == $past(global_irq_enable
                                     && cmp_b_irq_enable && flags[CMP_B_BIT])))
      else $error("compare irq does not follow its gate");
   a_ovf_flag_set: assert property (ce && flag_set[OVF_BIT] |=> flags[OVF_BIT])
      else $error("overflow flag not set");
   a_bottom_turn: assert property (ce && phase_correct_mode && bottom_turn |=> flags[OVF_BIT])
      else $error("bottom turn did not set overflow flag");
   a_cmp_a_set: assert property (ce && cmp_a_match |=> flags[CMP_A_BIT])
      else $error("compare a flag not set");
   a_cmp_b_set: assert property (ce && cmp_b_match |=> flags[CMP_B_BIT])
      else $error("compare b flag not set");
   a_ack_clears_flag: assert property (ce && vector_ack[CMP_B_BIT] && !cmp_b_match
                                       |=> !flags[CMP_B_BIT])
      else $error("vector ack did not clear flag");
   a_w1c_flag: assert property (ce && wr_flags && wdata[CMP_A_BIT] && !cmp_a_match
                                |=> !flags[CMP_A_BIT])
      else $error("write one did not clear flag");
   a_w0_keeps_flag: assert property (ce && wr_flags && !wdata[OVF_BIT] && flags[OVF_BIT]
                                     && !vector_ack[OVF_BIT] |=> flags[OVF_BIT])
      else $error("write zero changed flag");
   a_ext_buffer: assert property (ce |=> ext_clock_buffer_en == $past(ext_clock_input_enable
                                         && async_clock_select))
      else $error("external clock buffer enable wrong");
   a_busy_on_write: assert property (ce && async_clock_select && wr_en && hit_busy[BUSY_COUNTER]
                                     |=> update_busy[BUSY_COUNTER])
      else $error("counter write did not set busy");
   a_sync_no_busy: assert property (ce && !async_clock_select |=> update_busy == 5'h00)
      else $error("busy set in synchronous clocking");
   a_hold_in_sync: assert property (ce && !wr_gen && sync_mode_hold && shared_prescaler_reset
                                    |=> shared_prescaler_reset)
      else $error("prescaler reset dropped in sync mode");
   a_release_clears: assert property (s_release_sync ##1 s_quiet_cycle
                                      |=> !shared_prescaler_reset && (!async_prescaler_reset
                                          || $past(async_clock_select && !async_psr_done)))
      else $error("release of sync mode left reset bits");
   a_shared_autoclr: assert property (ce && !wr_gen && !sync_mode_hold |=> !shared_prescaler_reset)
      else $error("shared prescaler reset not cleared");
   a_async_psr_wait: assert property (ce && !wr_gen && async_clock_select && async_prescaler_reset
                                      && !async_psr_done |=> async_prescaler_reset)
      else $error("async prescaler reset cleared early");
   a_crystal_run: assert property (ce |=> crystal_osc_run == $past(!ext_clock_input_enable
                                          && async_clock_select))
      else $error("crystal oscillator run wrong");
   a_ack_clears_ovf: assert property (ce && vector_ack[OVF_BIT] && !flag_set[OVF_BIT]
                                      |=> !flags[OVF_BIT])
      else $error("overflow vector ack did not clear flag");
   a_async_sel_write: assert property (ce && wr_async
                                       |=> async_clock_select == $past(wdata[ASYNC_SEL_BIT]))
      else $error("async select did not take written value");
   a_busy_clear_done: assert property (ce && update_done[BUSY_CMP_A] && !busy_set[BUSY_CMP_A]
                                       |=> !update_busy[BUSY_CMP_A])
      else $error("busy not cleared after transfer");
   a_async_hold_sync: assert property (ce && !wr_gen && sync_mode_hold && async_prescaler_reset
                                       |=> async_prescaler_reset)
      else $error("async prescaler reset dropped in sync mode");
   a_sync_psr_clear: assert property (ce && !wr_gen && !sync_mode_hold && !async_clock_select
                                      |=> !async_prescaler_reset)
      else $error("async prescaler reset not cleared in sync clocking");
endmodule
`default_nettype wire

//--- tb/timer2_async_flag_prescaler_ctl_tb.sv
/*
 * self-checking bench for the timer 2 flag, asynchronous status and general control block.
 * assumes the design package is compiled first and the bench stands in for cpu and counter core.
 */
`timescale 1ns/1ns
`default_nettype none
module timer2_async_flag_prescaler_ctl_tb;
   import timer2_ctl_pkg::*;
   // ----------------------------------------------------------------------
   // stimulus and observation
   // ----------------------------------------------------------------------
   logic       core_clk = 1'b0;
   logic       rst_b = 1'b0;
   logic       ce = 1'b1;
   logic [7:0] addr = 8'h00;
   logic       io_space = 1'b0;
   logic       wr_en = 1'b0;
   logic       rd_en = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic       gie = 1'b0;
   logic [2:0] ien = 3'h0;
   logic [2:0] vector_ack = 3'h0;
   logic [2:0] irq;
   logic       ovf = 1'b0;
   logic       pcm = 1'b0;
   logic       bot = 1'b0;
   logic       ma = 1'b0;
   logic       mb = 1'b0;
   logic [4:0] upd = 5'h00;
   logic       psr_done = 1'b0;
   logic       as_sel;
   logic       ext_en;
   logic       xtal;
   logic       apsr;
   logic       spsr;
   int         err_count = 0;
   int         compares = 0;
   always #50 core_clk = ~core_clk;
   timer2_async_flag_prescaler_ctl dut (
      .core_clk(core_clk), .rst_b(rst_b), .ce(ce), .addr(addr), .io_space(io_space),
      .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata), .rdata(rdata), .global_irq_enable(gie),
      .overflow_irq_enable(ien[0]), .cmp_a_irq_enable(ien[1]), .cmp_b_irq_enable(ien[2]),
      .vector_ack(vector_ack), .overflow_irq(irq[0]), .cmp_a_irq(irq[1]), .cmp_b_irq(irq[2]),
      .counter_overflow(ovf), .phase_correct_mode(pcm), .bottom_turn(bot), .cmp_a_match(ma),
      .cmp_b_match(mb), .update_done(upd), .async_psr_done(psr_done),
      .async_clock_select(as_sel), .ext_clock_buffer_en(ext_en), .crystal_osc_run(xtal),
      .async_prescaler_reset(apsr), .shared_prescaler_reset(spsr));
   // ----------------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------------
   task automatic tick(input int n = 1);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic print_verdict;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp, input string what);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t %s got %b want %b", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic io, input logic [7:0] d);
      addr = a;
      io_space = io;
      wdata = d;
      wr_en = 1'b1;
      tick();
      wr_en = 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic io, input logic [7:0] exp);
      addr = a;
      io_space = io;
      rd_en = 1'b1;
      tick();
      rd_en = 1'b0;
      chk8(rdata, exp, "read");
   endtask
   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   // a clock edge passes between strobes so no strobe is lowered and raised at once
   task automatic t_reset_map;
      rchk(IRQ_FLAGS_OFS, 1'b0, REG_RESET);
      tick();
      rchk(GEN_CTRL_OFS, 1'b0, REG_RESET);
      tick();
      rchk(ASYNC_STAT_OFS, 1'b0, REG_RESET);
      tick();
      rchk(8'h17, 1'b1, REG_RESET);
      tick();
      rchk(8'h23, 1'b1, REG_RESET);
      tick();
      rchk(8'h55, 1'b0, 8'h00);
      chk8({irq, as_sel, ext_en, xtal, apsr, spsr}, 8'h00, "outputs after reset");
   endtask
   task automatic t_flags;
      ien = 3'h7;
      ovf = 1'b1;
      ma = 1'b1;
      mb = 1'b1;
      tick();
      {ovf, ma, mb} = 3'h0;
      tick();
      chk8({5'h0, irq}, 8'h00, "irq without global enable");
      gie = 1'b1;
      tick();
      chk8({5'h0, irq}, 8'h07, "irq all enabled");
      rchk(8'h17, 1'b1, 8'h07);
      wr(IRQ_FLAGS_OFS, 1'b0, 8'hf8);
      rchk(IRQ_FLAGS_OFS, 1'b0, 8'h07);
      wr(IRQ_FLAGS_OFS, 1'b0, 8'h02);
      rchk(IRQ_FLAGS_OFS, 1'b0, 8'h05);
      ien[2] = 1'b0;
      tick(2);
      chk8({5'h0, irq}, 8'h01, "compare b masked");
      vector_ack = 3'h1;
      tick();
      vector_ack = 3'h4;
      tick();
      vector_ack = 3'h0;
      rchk(IRQ_FLAGS_OFS, 1'b0, 8'h00);
      tick();
      chk8({5'h0, irq}, 8'h00, "irq after vectors");
      // set must win when the clear lands on the same edge
      ovf = 1'b1;
      wr(IRQ_FLAGS_OFS, 1'b0, 8'h01);
      ovf = 1'b0;
      rchk(IRQ_FLAGS_OFS, 1'b0, 8'h01);
      wr(8'h17, 1'b1, 8'h01);
      ce = 1'b0;
      ma = 1'b1;
      tick();
      ma = 1'b0;
      ce = 1'b1;
      rchk(IRQ_FLAGS_OFS, 1'b0, 8'h00);
   endtask
   task automatic t_phase_correct;
      pcm = 1'b1;
      ovf = 1'b1;
      tick();
      ovf = 1'b0;
      rchk(IRQ_FLAGS_OFS, 1'b0, 8'h00);
      bot = 1'b1;
      tick();
      bot = 1'b0;
      rchk(IRQ_FLAGS_OFS, 1'b0, 8'h01);
      wr(IRQ_FLAGS_OFS, 1'b0, 8'h01);
      pcm = 1'b0;
   endtask
   task automatic t_async;
      tick();
      wr(COUNTER_OFS, 1'b0, 8'h5a);
      rchk(ASYNC_STAT_OFS, 1'b0, 8'h00);
      // external clock bit goes in before the select is raised
      wr(ASYNC_STAT_OFS, 1'b0, 8'h40);
      tick();
      chk8({5'h0, as_sel, ext_en, xtal}, 8'h00, "ext without select");
      wr(ASYNC_STAT_OFS, 1'b0, 8'h60);
      tick();
      chk8({5'h0, as_sel, ext_en, xtal}, 8'h06, "ext clock");
      wr(ASYNC_STAT_OFS, 1'b0, 8'h3f);
      tick();
      chk8({5'h0, as_sel, ext_en, xtal}, 8'h05, "crystal");
      rchk(ASYNC_STAT_OFS, 1'b0, 8'h20);
      // select changed: all five timer registers rewritten, each while idle
      for (int i = 0; i < 5; i++) begin
         wr(CONTROL_A_OFS + 8'(i), 1'b0, 8'h5a);
         tick();
      end
      rchk(ASYNC_STAT_OFS, 1'b0, 8'h3f);
      upd = 5'h10;
      tick();
      upd = 5'h00;
      rchk(ASYNC_STAT_OFS, 1'b0, 8'h2f);
      upd = 5'h0f;
      tick();
      upd = 5'h00;
      rchk(ASYNC_STAT_OFS, 1'b0, 8'h20);
      wr(CONTROL_B_OFS, 1'b0, 8'h01);
      tick();
      rchk(ASYNC_STAT_OFS, 1'b0, 8'h21);
      wr(ASYNC_STAT_OFS, 1'b0, 8'h00);
      tick();
      rchk(ASYNC_STAT_OFS, 1'b0, 8'h00);
   endtask
   task automatic t_prescaler;
      wr(GEN_CTRL_OFS, 1'b0, 8'h03);
      chk8({6'h0, apsr, spsr}, 8'h03, "reset bits set");
      tick();
      chk8({6'h0, apsr, spsr}, 8'h00, "reset bits self clear");
      wr(8'h23, 1'b1, 8'h83);
      tick(3);
      chk8({6'h0, apsr, spsr}, 8'h03, "held in sync mode");
      rchk(GEN_CTRL_OFS, 1'b0, 8'h83);
      wr(GEN_CTRL_OFS, 1'b0, 8'h00);
      tick();
      chk8({6'h0, apsr, spsr}, 8'h00, "sync mode left");
      wr(ASYNC_STAT_OFS, 1'b0, 8'h20);
      tick();
      wr(GEN_CTRL_OFS, 1'b0, 8'h02);
      tick(3);
      chk1(apsr, 1'b1, "async reset waits");
      psr_done = 1'b1;
      tick();
      psr_done = 1'b0;
      tick();
      chk1(apsr, 1'b0, "async reset done");
      wr(GEN_CTRL_OFS, 1'b0, 8'h82);
      psr_done = 1'b1;
      tick();
      psr_done = 1'b0;
      tick();
      chk1(apsr, 1'b1, "async reset held by sync mode");
      wr(GEN_CTRL_OFS, 1'b0, 8'h00);
      tick(2);
      chk1(apsr, 1'b0, "async reset after sync mode");
   endtask
   // ----------------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------------
   initial begin
      tick(10);
      rst_b = 1'b1;
      t_reset_map();
      t_flags();
      t_phase_correct();
      t_async();
      t_prescaler();
      print_verdict();
   end
   // the whole run needs about a hundred cycles, so this limit only trips on a hang
   initial begin
      repeat (5000) @(posedge core_clk);
      err_count++;
      $display("BAD %0t watchdog expired", $time);
      print_verdict();
   end
endmodule
`default_nettype wire
